// File: rtws_pkg.sv
// Shared constants and types for the reset timer, watchdog and sleep block.
package rtws_pkg;

  // Both RC oscillators are nominally 1 MHz, one tick per microsecond.
  localparam int RC_PERIOD_NS = 1000;

  // Hold-off after reset, in its own unit and in RC ticks.
  localparam int HOLD_TIME_MS = 18;
  localparam int HOLD_TICKS   = HOLD_TIME_MS * 1000000 / RC_PERIOD_NS;

  // Watchdog base period without prescaling.
  localparam int WDT_TIME_MS  = 18;
  localparam int WDT_TICKS    = WDT_TIME_MS * 1000000 / RC_PERIOD_NS;

  // Prescaler reaches 1:128, so seven stages.
  localparam int PRESC_BITS   = 7;

  // Register offsets on the plain register port.
  localparam logic [3:0] REG_OPTION = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;

  // Option register layout and reset value.
  localparam int OPT_WIDTH        = 6;
  localparam int OPT_CLK_SRC_BIT  = 5;
  localparam int OPT_EDGE_BIT     = 4;
  localparam int OPT_ASSIGN_BIT   = 3;
  localparam int OPT_RATE_LSB     = 0;
  localparam logic [5:0] OPTION_RESET = 6'h3f;

  // Flag positions in the status byte.
  localparam int STATUS_EXPIRY_BIT = 4;
  localparam int STATUS_SLEEP_BIT  = 3;

  typedef struct packed {
    logic       timer_clock_source_sel;
    logic       timer_edge_sel;
    logic       prescaler_assign;
    logic [2:0] prescaler_rate;
  } rtws_option_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtws_bus_req_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_HOLD  = 2'b10
  } rtws_state_t;

endpackage : rtws_pkg

// File: rtws_hold_timer.sv
// Reset hold-off timer counting ticks of its own RC oscillator.
`timescale 1ns/1ps
module rtws_hold_timer #(
  parameter int TICKS = rtws_pkg::HOLD_TICKS
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic restart,
  input  wire logic run,
  input  wire logic tick,
  output logic      active
);

  localparam int CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

  logic [CW-1:0] count;
  wire           step = active & run & tick & ~restart;
  wire           last = (count == LAST);

  // Power-up leaves the timer cleared and armed.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count  <= '0;
      active <= 1'b1;
    end else if (restart) begin
      count  <= '0;
      active <= 1'b1;
    end else if (step) begin
      count  <= last ? '0 : count + CW'(1);
      active <= ~last;
    end
  end

  // Apart from a restart, only an RC tick moves the count, never the system clock alone.
  a_count_on_tick: assert property (@(posedge sys_clk) disable iff (rst)
    !tick && !restart |=> $stable(count))
    else $error("hold count moved without an RC tick");

  // Counting waits for the pin to read high; a low pin keeps it armed at 0.
  a_wait_pin_high: assert property (@(posedge sys_clk) disable iff (rst)
    !run |=> count == '0 && active)
    else $error("hold timer advanced while pin low");

endmodule : rtws_hold_timer

// File: rtws_watchdog.sv
// Watchdog counter with the shared prescaler in front of it.
`timescale 1ns/1ps
module rtws_watchdog #(
  parameter int BASE_TICKS = rtws_pkg::WDT_TICKS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic       presc_assign,
  input  wire logic [2:0] rate,
  output logic            expire
);

  localparam int CW = $clog2(BASE_TICKS + 1);
  localparam int PW = rtws_pkg::PRESC_BITS;
  localparam logic [CW-1:0] LAST = CW'(BASE_TICKS - 1);

  logic [CW-1:0] count;
  logic [PW-1:0] presc;

  // Rate 0 divides by one, rate 7 by 128.
  wire [PW-1:0] presc_top = {PW{1'b1}} >> (3'd7 - rate);
  wire          presc_hit = ~presc_assign | (presc == presc_top);
  wire          base_hit  = (count == LAST);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count  <= '0;
      presc  <= '0;
      expire <= 1'b0;
    end else if (clear || !enable) begin
      // A disabled watchdog never expires.
      count  <= '0;
      presc  <= '0;
      expire <= 1'b0;
    end else if (tick) begin
      presc  <= presc_hit ? '0 : presc + PW'(1);
      count  <= presc_hit ? (base_hit ? '0 : count + CW'(1)) : count;
      expire <= presc_hit & base_hit;
    end else begin
      expire <= 1'b0;
    end
  end

  a_clear_zeroes: assert property (@(posedge sys_clk) disable iff (rst)
    clear |=> count == '0 && presc == '0 && !expire)
    else $error("watchdog not zeroed by clear");

  a_fuse_blocks: assert property (@(posedge sys_clk) disable iff (rst)
    !enable |=> !expire)
    else $error("watchdog expired while disabled");

endmodule : rtws_watchdog

// File: rtws_reset_ctrl.sv
// Reset hold, watchdog and sleep control with reset-cause flags.
//
// How it works
// - Hold-off after a trigger lasts a fixed nominal 18 ms.
// - The core stays in reset and runs nothing while hold-off counts.
// - Hold-off counts ticks of its own RC oscillator.
// - Hold-off starts counting only once the clear pin reads high.
// - Watchdog expiry restarts the full hold-off.
// - Watchdog runs on its own RC ticks, also during sleep.
// - Expiry fully resets the device, running or asleep.
// - Enable fuse at zero disables the watchdog for good.
// - Base period 18 ms, prescaler stretches it up to 1:128.
// - Clear instruction zeroes watchdog and assigned prescaler.
// - Sleep instruction zeroes watchdog and assigned prescaler.
// - Option holds six bits, reset to all ones, upper bits zero.
// - Flag pair encodes power-up, pin wake, expiry, expiry wake.
// - A pin reset while running leaves both flags unchanged.
// - Only power-up, expiry, sleep and clear instruction change flags.
// - Expiry and sleep act whatever the current flag values.
// - Sleep stops the oscillator driver and freezes the I/O pins.
// - Watchdog reset is internal and never drives the clear pin.
// - Only a low pin or an enabled expiry ends sleep, by reset.
// - Waking from sleep clears the watchdog.
// - Verification readout is allowed only while unprotected.
// - Power-up sets the reset latch; hold-off expiry releases it.
`timescale 1ns/1ps
module rtws_reset_ctrl #(
  parameter int HOLD_TICKS = rtws_pkg::HOLD_TICKS,
  parameter int WDT_TICKS  = rtws_pkg::WDT_TICKS
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire rtws_pkg::rtws_bus_req_t bus,
  output logic [7:0]                  rdata,
  input  wire logic                   drt_osc_tick,
  input  wire logic                   wdt_osc_tick,
  input  wire logic                   master_clear_pin_n,
  input  wire logic                   watchdog_enable_fuse,
  input  wire logic                   code_protect_fuse,
  input  wire logic                   watchdog_clear_instr,
  input  wire logic                   sleep_instr,
  output logic                        core_reset,
  output logic                        osc_driver_en,
  output logic                        io_hold,
  output logic                        expiry_flag_n,
  output logic                        sleep_entered_flag_n,
  output logic                        verify_read_en,
  output rtws_pkg::rtws_option_t      option
);

  function automatic logic hits(input logic [3:0] a,
                                input logic [3:0] r);
    hits = (a == r);
  endfunction : hits

  rtws_pkg::rtws_state_t state;
  rtws_pkg::rtws_state_t next_state;
  logic                  drt_active;
  logic                  wdt_expire;
  logic [7:0]            status_byte;

  // Instructions count only while the core really runs; an expiry in the
  // same cycle wins because the device is about to be reset anyway.
  wire in_run     = (state == rtws_pkg::ST_RUN);
  wire in_sleep   = (state == rtws_pkg::ST_SLEEP);
  wire in_hold    = (state == rtws_pkg::ST_HOLD);
  wire instr_ok   = in_run & master_clear_pin_n & ~wdt_expire;
  wire clr_take   = instr_ok & watchdog_clear_instr;
  wire sleep_take = instr_ok & sleep_instr & ~watchdog_clear_instr;
  wire pin_low    = ~master_clear_pin_n;
  wire wake       = in_sleep & (pin_low | wdt_expire);

  // Both a low pin and an expiry rearm the hold-off.
  wire drt_restart = pin_low | wdt_expire;

  // The watchdog is cleared by its instruction, by sleep, on wake and
  // while the core is held, so it cannot fire twice for one reset.
  wire wdt_clear = clr_take | sleep_take | wake | in_hold;

  wire wr_option = bus.wr & hits(bus.addr, rtws_pkg::REG_OPTION) & ~in_hold;
  wire rd_status = bus.rd & hits(bus.addr, rtws_pkg::REG_STATUS);

  rtws_hold_timer #(
    .TICKS   (HOLD_TICKS)
  ) u_hold (
    .sys_clk (sys_clk),
    .rst     (rst),
    .restart (drt_restart),
    .run     (master_clear_pin_n),
    .tick    (drt_osc_tick),
    .active  (drt_active)
  );

  rtws_watchdog #(
    .BASE_TICKS   (WDT_TICKS)
  ) u_wdt (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .enable       (watchdog_enable_fuse),
    .clear        (wdt_clear),
    .tick         (wdt_osc_tick),
    .presc_assign (option.prescaler_assign),
    .rate         (option.prescaler_rate),
    .expire       (wdt_expire)
  );

  // Pin and expiry resets take the same path in every state, so a wake
  // from sleep is a full reset and never a resume.
  always_comb begin
    next_state = state;
    if (pin_low || wdt_expire) begin
      next_state = rtws_pkg::ST_HOLD;
    end else begin
      unique case (state)
        rtws_pkg::ST_RUN: begin
          if (sleep_take) begin
            next_state = rtws_pkg::ST_SLEEP;
          end
        end
        rtws_pkg::ST_SLEEP: begin
          next_state = rtws_pkg::ST_SLEEP;
        end
        rtws_pkg::ST_HOLD: begin
          if (!drt_active) begin
            next_state = rtws_pkg::ST_RUN;
          end
        end
        default: begin
          next_state = rtws_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // Power-up starts in the held state with the reset latch set.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state      <= rtws_pkg::ST_HOLD;
      core_reset <= 1'b1;
    end else begin
      state      <= next_state;
      core_reset <= (next_state == rtws_pkg::ST_HOLD);
    end
  end

  // Sleep turns the oscillator driver off and freezes the pins.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_driver_en <= 1'b1;
      io_hold       <= 1'b0;
    end else begin
      osc_driver_en <= (next_state != rtws_pkg::ST_SLEEP);
      io_hold       <= (next_state == rtws_pkg::ST_SLEEP);
    end
  end

  // A low pin alone never touches the flags; only the four events do.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      expiry_flag_n        <= 1'b1;
      sleep_entered_flag_n <= 1'b1;
    end else if (wdt_expire) begin
      expiry_flag_n        <= 1'b0;
    end else if (sleep_take) begin
      expiry_flag_n        <= 1'b1;
      sleep_entered_flag_n <= 1'b0;
    end else if (clr_take) begin
      expiry_flag_n        <= 1'b1;
      sleep_entered_flag_n <= 1'b1;
    end
  end

  // Every device reset returns the option bits to all ones.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      option <= rtws_pkg::OPTION_RESET;
    end else if (in_hold) begin
      option <= rtws_pkg::OPTION_RESET;
    end else if (wr_option) begin
      option <= rtws_pkg::rtws_option_t'(bus.wdata[rtws_pkg::OPT_WIDTH-1:0]);
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[rtws_pkg::STATUS_EXPIRY_BIT] = expiry_flag_n;
    status_byte[rtws_pkg::STATUS_SLEEP_BIT]  = sleep_entered_flag_n;
  end

  // The option register is write-only; it and unmapped offsets read zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_status ? status_byte : 8'h00;
    end
  end

  // Readout tracks the protect fuse; a programmed fuse reads zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      verify_read_en <= 1'b0;
    end else begin
      verify_read_en <= code_protect_fuse;
    end
  end

  // The clear pin is an input only; no path here can pull it low.

  a_hold_while_drt: assert property (@(posedge sys_clk) disable iff (rst)
    drt_active |=> core_reset)
    else $error("core released while hold-off active");

  a_release_on_done: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(core_reset) |-> !$past(drt_active) &&
      $past(master_clear_pin_n))
    else $error("reset released without hold-off expiry");

  a_expiry_restart: assert property (@(posedge sys_clk) disable iff (rst)
    wdt_expire |=> drt_active && core_reset)
    else $error("expiry did not restart hold-off");

  a_expiry_to_flag: assert property (@(posedge sys_clk) disable iff (rst)
    wdt_expire |=> !expiry_flag_n &&
      sleep_entered_flag_n == $past(sleep_entered_flag_n))
    else $error("expiry flag update wrong");

  a_sleep_flags: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_take |=> expiry_flag_n && !sleep_entered_flag_n &&
      io_hold && !osc_driver_en)
    else $error("sleep entry flags or pins wrong");

  a_clear_flags: assert property (@(posedge sys_clk) disable iff (rst)
    clr_take |=> expiry_flag_n && sleep_entered_flag_n)
    else $error("clear instruction did not set both flags");

  a_pin_keeps_flags: assert property (@(posedge sys_clk) disable iff (rst)
    pin_low && !wdt_expire |=> $stable(expiry_flag_n) &&
      $stable(sleep_entered_flag_n))
    else $error("pin reset changed a flag");

  a_sleep_exit_only: assert property (@(posedge sys_clk) disable iff (rst)
    in_sleep && master_clear_pin_n && !wdt_expire |=> in_sleep)
    else $error("sleep ended without a wake source");

  a_wake_resets: assert property (@(posedge sys_clk) disable iff (rst)
    wake |=> in_hold ##1 core_reset)
    else $error("wake did not reset the core");

  a_option_reset: assert property (@(posedge sys_clk) disable iff (rst)
    in_hold |=> option == rtws_pkg::OPTION_RESET)
    else $error("option not reset during hold");

  a_verify_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !code_protect_fuse |=> !verify_read_en)
    else $error("readout open while protected");

  a_read_status: assert property (@(posedge sys_clk) disable iff (rst)
    rd_status |=> rdata == $past(status_byte))
    else $error("status read data wrong");

  // The first four checks below tie the registered outputs back to the state.
  // They are cheap and catch a stale output after an odd state change.
  a_osc_off_sleep: assert property (@(posedge sys_clk) disable iff (rst)
    in_sleep |-> !osc_driver_en && io_hold)
    else $error("oscillator or pins wrong in sleep");

  a_osc_on_run: assert property (@(posedge sys_clk) disable iff (rst)
    in_run |-> osc_driver_en && !io_hold)
    else $error("oscillator or pins wrong while running");

  a_hold_is_reset: assert property (@(posedge sys_clk) disable iff (rst)
    in_hold |-> core_reset)
    else $error("core free while in hold state");

  a_drt_in_hold: assert property (@(posedge sys_clk) disable iff (rst)
    drt_active |-> in_hold)
    else $error("hold-off active outside hold state");

  a_pin_low_holds: assert property (@(posedge sys_clk) disable iff (rst)
    pin_low |=> core_reset && drt_active)
    else $error("low pin did not hold the core");

  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_status |=> rdata == 8'h00)
    else $error("read data not zero without status read");

  a_verify_open: assert property (@(posedge sys_clk) disable iff (rst)
    code_protect_fuse |=> verify_read_en)
    else $error("readout closed while unprotected");

  a_sleep_keeps_flags: assert property (@(posedge sys_clk) disable iff (rst)
    in_sleep && !wdt_expire |=> $stable(expiry_flag_n) &&
      $stable(sleep_entered_flag_n))
    else $error("flag changed during sleep");

  a_hold_keeps_flags: assert property (@(posedge sys_clk) disable iff (rst)
    in_hold && !wdt_expire |=> $stable(expiry_flag_n) &&
      $stable(sleep_entered_flag_n))
    else $error("flag changed during hold");

  a_sleep_entry: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_take |=> in_sleep)
    else $error("sleep instruction did not enter sleep");

  a_clear_keeps_run: assert property (@(posedge sys_clk) disable iff (rst)
    clr_take |=> in_run)
    else $error("clear instruction left the run state");

  a_write_option: assert property (@(posedge sys_clk) disable iff (rst)
    wr_option |=> option ==
      rtws_pkg::rtws_option_t'($past(bus.wdata[5:0])))
    else $error("option write did not land");

  a_expiry_wake_flags: assert property (@(posedge sys_clk) disable iff (rst)
    wake && wdt_expire |=> !expiry_flag_n &&
      !sleep_entered_flag_n)
    else $error("expiry wake flags wrong");

  a_pin_wake_flags: assert property (@(posedge sys_clk) disable iff (rst)
    wake && !wdt_expire |=> expiry_flag_n &&
      !sleep_entered_flag_n)
    else $error("pin wake flags wrong");

  a_rdata_unused: assert property (@(posedge sys_clk) disable iff (rst)
    rdata[7:5] == 3'b000 && rdata[2:0] == 3'b000)
    else $error("unused status bits not zero");

  a_fuse_no_expire: assert property (@(posedge sys_clk) disable iff (rst)
    !watchdog_enable_fuse |=> !wdt_expire)
    else $error("expiry seen with watchdog fused off");

  a_wake_clears: assert property (@(posedge sys_clk) disable iff (rst)
    wake |=> in_hold && drt_active)
    else $error("wake did not restart the hold-off");

  a_expiry_hold: assert property (@(posedge sys_clk) disable iff (rst)
    wdt_expire |=> in_hold)
    else $error("expiry did not reset the device");

endmodule : rtws_reset_ctrl

// File: rtws_core_model.sv
// Processor core model that issues the clear and sleep instructions.
`timescale 1ns/1ps
module rtws_core_model (
  input  wire logic sys_clk,
  input  wire logic core_reset,
  input  wire logic want_clear,
  input  wire logic want_sleep,
  output logic      watchdog_clear_instr,
  output logic      sleep_instr
);
  initial begin
    watchdog_clear_instr = 1'b0;
    sleep_instr = 1'b0;
  end
  // A core held in reset fetches nothing, so requests then are dropped.
  always @(posedge sys_clk) begin
    watchdog_clear_instr <= want_clear && core_reset === 1'b0;
    sleep_instr <= want_sleep && core_reset === 1'b0;
  end
endmodule : rtws_core_model

// File: tb_rtws_reset_ctrl.sv
// Self-checking bench for the reset timer, watchdog and sleep block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_rtws_reset_ctrl;
  localparam int HT = 4;
  localparam int WT = 5;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  rtws_pkg::rtws_bus_req_t bus = '0;
  logic drt_tick = 1'b0;
  logic wdt_tick = 1'b0;
  logic pin_n = 1'b0;
  logic wdt_fuse = 1'b1;
  logic cp_fuse = 1'b1;
  logic want_clear = 1'b0;
  logic want_sleep = 1'b0;
  logic [7:0] rdata;
  logic clr_i, slp_i, core_reset, osc_en, io_hold, to_n, pd_n, ver_en;
  rtws_pkg::rtws_option_t option;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int wcnt = 0;
  int dcnt = 0;
  int m_to = 1;
  int m_pd = 1;
  logic [15:0] seed = 16'hb513;

  rtws_reset_ctrl #(.HOLD_TICKS(HT), .WDT_TICKS(WT)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
    .drt_osc_tick(drt_tick), .wdt_osc_tick(wdt_tick),
    .master_clear_pin_n(pin_n), .watchdog_enable_fuse(wdt_fuse),
    .code_protect_fuse(cp_fuse), .watchdog_clear_instr(clr_i),
    .sleep_instr(slp_i), .core_reset(core_reset),
    .osc_driver_en(osc_en), .io_hold(io_hold), .expiry_flag_n(to_n),
    .sleep_entered_flag_n(pd_n), .verify_read_en(ver_en),
    .option(option));

  rtws_core_model u_core (
    .sys_clk(sys_clk), .core_reset(core_reset), .want_clear(want_clear),
    .want_sleep(want_sleep), .watchdog_clear_instr(clr_i),
    .sleep_instr(slp_i));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // The watchdog RC tick comes every second cycle and the hold-off tick every third, so they coincide every sixth cycle.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    wdt_tick <= (cyc % 2 == 0);
    drt_tick <= (cyc % 3 == 1);
    if (wdt_tick) wcnt <= wcnt + 1;
    if (drt_tick && pin_n) dcnt <= dcnt + 1;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk_flags;
    logic [1:0] e;
    e = {m_to[0], m_pd[0]};
    `CHK("flags", e, {to_n, pd_n})
  endtask : chk_flags

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    bus <= '0;
    #1 `CHK("rdata", e, rdata)
    @(posedge sys_clk);
  endtask : rd

  task automatic instr(input bit slp);
    if (slp) want_sleep <= 1'b1;
    else want_clear <= 1'b1;
    @(posedge sys_clk);
    want_sleep <= 1'b0;
    want_clear <= 1'b0;
    @(posedge sys_clk);
    m_to = 1;
    m_pd = slp ? 0 : 1;
  endtask : instr

  task automatic wait_run;
    int i;
    i = 0;
    while (core_reset !== 1'b0 && i < 2000) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    `CHK("release", 1'b0, core_reset)
    `CHK("io_hold", 1'b0, io_hold)
    `CHK("osc_en", 1'b1, osc_en)
    @(posedge sys_clk);
  endtask : wait_run

  task automatic pin_reset(input int nlow);
    int d0;
    pin_n <= 1'b0;
    repeat (nlow) @(posedge sys_clk);
    #1 `CHK("held", 1'b1, core_reset)
    @(posedge sys_clk);
    pin_n <= 1'b1;
    d0 = dcnt;
    wait_run;
    `CHK("hold", 1'b1, dcnt - d0 >= HT && dcnt - d0 <= HT + 1)
  endtask : pin_reset

  task automatic wdog(input logic a, input logic [2:0] r, input bit slp);
    int per, t0, d0, i;
    logic [5:0] ov;
    per = a ? WT << r : WT;
    seed = lfsr(seed);
    ov = {seed[5:4], a, r};
    wr(4'h0, {seed[7:6], ov});
    #1 `CHK("option", ov, option)
    // Let the count run halfway so a missed clear shows as an early expiry.
    repeat (per) @(posedge sys_clk);
    instr(slp);
    t0 = wcnt;
    #1 chk_flags();
    `CHK("io_hold", slp, io_hold)
    i = 0;
    while (core_reset !== 1'b1 && i < 2 * per + 40) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    `CHK("period", 1'b1, wcnt - t0 >= per - 1 && wcnt - t0 <= per + 2)
    d0 = dcnt;
    m_to = 0;
    repeat (2) @(posedge sys_clk);
    #1 chk_flags();
    `CHK("opt reset", 6'h3f, option)
    @(posedge sys_clk);
    wait_run;
    `CHK("rehold", 1'b1, dcnt - d0 >= HT)
  endtask : wdog

  initial begin
    repeat (2) @(posedge sys_clk);
    #1 `CHK("core_reset", 1'b1, core_reset)
    `CHK("option", 6'h3f, option)
    chk_flags();
    @(posedge sys_clk);
    rst <= 1'b0;
    pin_reset(20);
    rd(rtws_pkg::REG_STATUS, 8'h18);
    rd(rtws_pkg::REG_OPTION, 8'h00);
    rd(4'h9, 8'h00);
    wr(4'h7, 8'h00);
    #1 `CHK("option", 6'h3f, option)
    @(posedge sys_clk);
    cp_fuse <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("verify", 1'b0, ver_en)
    @(posedge sys_clk);
    cp_fuse <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("verify", 1'b1, ver_en)
    @(posedge sys_clk);
    for (int r = 0; r < 8; r++) wdog(1'b1, r[2:0], 1'b0);
    wdog(1'b0, 3'h5, 1'b0);
    pin_reset(3);
    chk_flags();
    instr(1'b0);
    #1 chk_flags();
    @(posedge sys_clk);
    wdog(1'b1, 3'h1, 1'b1);
    wdt_fuse <= 1'b0;
    wr(4'h0, 8'h00);
    instr(1'b1);
    repeat (100) @(posedge sys_clk);
    #1 `CHK("no expiry", 1'b0, core_reset)
    `CHK("asleep", 1'b1, io_hold)
    @(posedge sys_clk);
    pin_reset(3);
    chk_flags();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end
endmodule : tb_rtws_reset_ctrl
